// [mra_pkg.sv]
// shared constants for the mode register access unit
package mra_pkg;
	// ------------------------------------------------------------
	// clock and latencies
	// ------------------------------------------------------------
	localparam int CLK_PS = 5000;
	localparam int CLK_PER_MS = 200000;
	localparam int READ_LATENCY = 3;
	localparam int WRITE_LATENCY = 1;
	localparam int BURST_LEN = 4;
	localparam int MRR_BEATS = 4;
	localparam int MODE_READ_PERIOD = 2;
	localparam int MODE_WRITE_PERIOD = 5;
	localparam int INIT_PERIOD = 16;
	localparam int WTR_TURNAROUND_PS = 7500;
	localparam int WTR_CYCLES = (WTR_TURNAROUND_PS + CLK_PS - 1) / CLK_PS;
	localparam int WR_TO_MRR_CYCLES =
		WRITE_LATENCY + 1 + BURST_LEN / 2 + WTR_CYCLES;
	localparam int RD_TO_MRR_CYCLES = BURST_LEN / 2;
	localparam int MRR_TURN_CYCLES = READ_LATENCY + MRR_BEATS + 3;
	// ------------------------------------------------------------
	// temperature sensor timing
	// ------------------------------------------------------------
	localparam int SENSOR_UPDATE_INTERVAL_MS = 32;
	localparam int SENSOR_UPDATE_CYCLES =
		SENSOR_UPDATE_INTERVAL_MS * CLK_PER_MS;
	localparam int TEMPERATURE_SLEW_LIMIT = 10;
	localparam int SYSTEM_REACTION_DELAY_MS = 1;
	localparam int TEMPERATURE_REACTION_MARGIN = 2;
	localparam int STATUS_POLL_PERIOD_MS =
		TEMPERATURE_REACTION_MARGIN * 1000 / TEMPERATURE_SLEW_LIMIT -
		SENSOR_UPDATE_INTERVAL_MS - SYSTEM_REACTION_DELAY_MS;
	localparam int STATUS_POLL_CYCLES = STATUS_POLL_PERIOD_MS * CLK_PER_MS;
	// ------------------------------------------------------------
	// command encodings and field positions
	// ------------------------------------------------------------
	localparam logic [3:0] CA_MRW = 4'h0;
	localparam logic [3:0] CA_MRR = 4'h8;
	localparam int CA_OP_LSB = 0;
	localparam int CA_ADDR_LO_LSB = 4;
	localparam int CA_ADDR_HI_LSB = 0;
	localparam int CA_DATA_LSB = 2;
	// ------------------------------------------------------------
	// mode register addresses, patterns and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] MR_TEMP_STATUS = 8'h04;
	localparam logic [7:0] MR_CALIB_A = 8'h20;
	localparam logic [7:0] MR_CALIB_B = 8'h28;
	localparam logic [7:0] MR_RESET = 8'h3f;
	localparam logic [3:0] CALIB_PATTERN_A = 4'h5;
	localparam logic [3:0] CALIB_PATTERN_B = 4'hc;
	localparam logic [7:0] MR_DEFAULT = 8'h00;
	localparam logic [2:0] TEMP_STATUS_RESET = 3'h3;
endpackage

// [mra_link_if.sv]
// command/address and data link between controller and device
`timescale 1ns/10ps
interface mra_link_if;
	logic cs_n;
	logic cke;
	logic [9:0] ca_rise;
	logic [9:0] ca_fall;
	logic [15:0] dq;
	logic dq_oe;
	logic dqs;
	modport dev (
		input cs_n, cke, ca_rise, ca_fall,
		output dq, dq_oe, dqs
	);
	modport ctrl (
		output cs_n, cke, ca_rise, ca_fall,
		input dq, dq_oe, dqs
	);
endinterface

// [mra_mem_device.sv]
// device end: mode register decode, read bursts and temperature status
// What this block does
// - controller spaces read after write burst
// - controller sends only NOP during read period
// - temperature status readable in three-bit field
// - status fresh on power down exit
// - controller poll period bounded by slew budget
// - calibration registers return fixed patterns
// - pattern A 1010, pattern B 0011
// - all data lines copy line zero
// - calibration reads only from idle
// - four-beat read burst always completes
// - write decoded from cs low, ca3..0 low
// - address is fall[1:0] above rise[9:4]
// - write data on fall[9:2]
// - writes to read-only registers ignored
// - writes only with all banks idle
// - NOP during write period, then idle
// - reads allowed when active, writes not
// - return idle; reset form initialises first
// - read decoded from ca3 high, ca2..0 low
// - value on low byte, first beat only
// - read command period two cycles
// - reset form restores register defaults
`timescale 1ns/10ps
module mra_mem_device #(
	parameter int SENSOR_CYCLES = mra_pkg::SENSOR_UPDATE_CYCLES,
	parameter int WRITE_CYCLES = mra_pkg::MODE_WRITE_PERIOD,
	parameter int INIT_CYCLES = mra_pkg::INIT_PERIOD
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// link
	mra_link_if.dev link,
	// device side
	input wire logic i_banks_active,
	input wire logic [2:0] i_temp_sensor,
	output logic o_idle,
	output logic o_initializing,
	output logic o_mr_wr_valid,
	output logic [7:0] o_mr_wr_addr,
	output logic [7:0] o_mr_wr_data
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE,
		ST_INIT
	} mra_dev_state_t;

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	wire cmd_valid = ~link.cs_n & link.cke;
	wire [3:0] ca_op = link.ca_rise[mra_pkg::CA_OP_LSB +: 4];
	wire is_mrw = cmd_valid & (ca_op == mra_pkg::CA_MRW);
	wire is_mrr = cmd_valid & (ca_op == mra_pkg::CA_MRR);
	wire [7:0] cmd_addr = {link.ca_fall[mra_pkg::CA_ADDR_HI_LSB +: 2],
		link.ca_rise[mra_pkg::CA_ADDR_LO_LSB +: 6]};
	wire [7:0] cmd_data = link.ca_fall[mra_pkg::CA_DATA_LSB +: 8];
	wire addr_cal_a = cmd_addr == mra_pkg::MR_CALIB_A;
	wire addr_cal_b = cmd_addr == mra_pkg::MR_CALIB_B;
	wire addr_temp = cmd_addr == mra_pkg::MR_TEMP_STATUS;
	wire addr_ro = addr_cal_a | addr_cal_b | addr_temp;
	wire addr_reset = cmd_addr == mra_pkg::MR_RESET;

	mra_dev_state_t state_reg;
	mra_dev_state_t state_next;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [7:0] mr_mem [0:255];
	logic [3:0] wait_reg;
	logic [2:0] beat_reg;
	logic burst_reg;
	logic cal_reg;
	logic [3:0] pattern_reg;
	logic [7:0] value_reg;
	logic [15:0] dq_reg;
	logic dq_oe_reg;
	logic dqs_reg;
	logic [2:0] sens_meta_reg;
	logic [2:0] sens_sync_reg;
	logic [2:0] temp_status_reg;
	logic [31:0] sens_cnt_reg;
	logic cke_d_reg;
	logic wr_valid_reg;
	logic [7:0] wr_addr_reg;
	logic [7:0] wr_data_reg;

	// ------------------------------------------------------------
	// state sequencing
	// ------------------------------------------------------------
	wire in_idle = state_reg == ST_IDLE;
	wire take_mrr = in_idle & is_mrr & ~burst_reg;
	wire take_mrw = in_idle & is_mrw & ~i_banks_active;
	wire take_reset = take_mrw & addr_reset;
	wire store_mrw = take_mrw & ~addr_reset & ~addr_ro;
	wire cnt_done = cnt_reg == 16'h0000;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (take_mrr) begin
					state_next = ST_READ;
					cnt_next = 16'(mra_pkg::MODE_READ_PERIOD - 1);
				end else if (take_reset) begin
					state_next = ST_INIT;
					cnt_next = 16'(INIT_CYCLES - 1);
				end else if (take_mrw) begin
					state_next = ST_WRITE;
					cnt_next = 16'(WRITE_CYCLES - 1);
				end
			end
			ST_READ, ST_WRITE, ST_INIT: begin
				if (cnt_done) begin
					state_next = ST_IDLE;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	// ------------------------------------------------------------
	// writable mode registers
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		for (int i = 0; i < 256; i++) begin
			if (i_reset | take_reset) begin
				mr_mem[i] <= mra_pkg::MR_DEFAULT;
			end else if (store_mrw & (cmd_addr == 8'(i))) begin
				mr_mem[i] <= cmd_data;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			wr_valid_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
		end else begin
			wr_valid_reg <= store_mrw;
			if (store_mrw) begin
				wr_addr_reg <= cmd_addr;
				wr_data_reg <= cmd_data;
			end
		end
	end

	// ------------------------------------------------------------
	// temperature status
	// ------------------------------------------------------------
	wire sens_tick = sens_cnt_reg == 32'(SENSOR_CYCLES - 1);
	wire lp_exit = link.cke & ~cke_d_reg;

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			sens_meta_reg <= 3'h0;
			sens_sync_reg <= 3'h0;
			sens_cnt_reg <= 32'h0000_0000;
			temp_status_reg <= mra_pkg::TEMP_STATUS_RESET;
			cke_d_reg <= 1'b1;
		end else begin
			sens_meta_reg <= i_temp_sensor;
			sens_sync_reg <= sens_meta_reg;
			cke_d_reg <= link.cke;
			if (sens_tick | lp_exit) begin
				sens_cnt_reg <= 32'h0000_0000;
				temp_status_reg <= sens_sync_reg;
			end else begin
				sens_cnt_reg <= sens_cnt_reg + 32'h0000_0001;
			end
		end
	end

	// ------------------------------------------------------------
	// read burst
	// ------------------------------------------------------------
	wire [7:0] rd_value = addr_temp ? {5'h00, temp_status_reg} :
		mr_mem[cmd_addr];
	wire [3:0] rd_pattern = addr_cal_a ? mra_pkg::CALIB_PATTERN_A :
		mra_pkg::CALIB_PATTERN_B;
	wire beat_on = burst_reg & (wait_reg == 4'h0);
	wire [1:0] beat_idx = beat_reg[1:0];
	wire [15:0] beat_data = cal_reg ? {16{pattern_reg[beat_idx]}} :
		((beat_idx == 2'h0) ? {8'h00, value_reg} : 16'h0000);

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			burst_reg <= 1'b0;
			wait_reg <= 4'h0;
			beat_reg <= 3'h0;
			cal_reg <= 1'b0;
			pattern_reg <= 4'h0;
			value_reg <= 8'h00;
			dq_reg <= 16'h0000;
			dq_oe_reg <= 1'b0;
			dqs_reg <= 1'b0;
		end else begin
			dq_oe_reg <= beat_on;
			dq_reg <= beat_on ? beat_data : 16'h0000;
			dqs_reg <= beat_on ? ~dqs_reg : 1'b0;
			if (take_mrr) begin
				burst_reg <= 1'b1;
				wait_reg <= 4'(mra_pkg::READ_LATENCY - 1);
				beat_reg <= 3'h0;
				cal_reg <= addr_cal_a | addr_cal_b;
				pattern_reg <= rd_pattern;
				value_reg <= rd_value;
			end else if (burst_reg & (wait_reg != 4'h0)) begin
				wait_reg <= wait_reg - 4'h1;
			end else if (beat_on) begin
				beat_reg <= beat_reg + 3'h1;
				if (beat_reg == 3'(mra_pkg::MRR_BEATS - 1)) begin
					burst_reg <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign link.dq = dq_reg;
	assign link.dq_oe = dq_oe_reg;
	assign link.dqs = dqs_reg;
	assign o_idle = in_idle;
	assign o_initializing = state_reg == ST_INIT;
	assign o_mr_wr_valid = wr_valid_reg;
	assign o_mr_wr_addr = wr_addr_reg;
	assign o_mr_wr_data = wr_data_reg;
endmodule

// [mra_mem_ctrl.sv]
// controller end: issues mode register commands and polls temperature
`timescale 1ns/10ps
module mra_mem_ctrl #(
	parameter int POLL_CYCLES = mra_pkg::STATUS_POLL_CYCLES,
	parameter int WRITE_CYCLES = mra_pkg::MODE_WRITE_PERIOD,
	parameter int INIT_CYCLES = mra_pkg::INIT_PERIOD
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// link
	mra_link_if.ctrl link,
	// request
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic [7:0] i_req_addr,
	input wire logic [7:0] i_req_data,
	output logic o_req_ready,
	// array traffic and bank state
	input wire logic i_banks_idle,
	input wire logic i_array_write,
	input wire logic i_array_read,
	input wire logic i_power_down,
	// answer
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	output logic [3:0] o_rd_cal,
	output logic [2:0] o_temp_status
);
	typedef enum logic {
		CS_IDLE,
		CS_WAIT
	} mra_ctrl_state_t;

	mra_ctrl_state_t state_reg;
	logic [15:0] wait_reg;
	logic [7:0] gap_reg;
	logic [31:0] poll_cnt_reg;
	logic poll_pend_reg;
	logic poll_rd_reg;
	logic cs_n_reg;
	logic cke_reg;
	logic [9:0] ca_rise_reg;
	logic [9:0] ca_fall_reg;
	logic [2:0] beat_reg;
	logic [7:0] rd_data_reg;
	logic [3:0] rd_cal_reg;
	logic rd_valid_reg;
	logic [2:0] temp_reg;

	// ------------------------------------------------------------
	// issue decisions
	// ------------------------------------------------------------
	wire idle = (state_reg == CS_IDLE) & cke_reg & ~i_power_down;
	wire gap_ok = gap_reg == 8'h00;
	wire req_cal = (i_req_addr == mra_pkg::MR_CALIB_A) |
		(i_req_addr == mra_pkg::MR_CALIB_B);
	wire req_reset = i_req_addr == mra_pkg::MR_RESET;
	wire rd_ok = gap_ok & (~req_cal | i_banks_idle);
	wire wr_ok = i_banks_idle;
	wire issue_poll = idle & poll_pend_reg & gap_ok;
	wire req_ok = i_req_write ? wr_ok : rd_ok;
	wire issue_req = idle & ~poll_pend_reg & i_req_valid & req_ok;
	wire is_wr = issue_req & i_req_write;
	wire [7:0] cmd_addr = issue_poll ? mra_pkg::MR_TEMP_STATUS : i_req_addr;
	wire [3:0] cmd_op = is_wr ? mra_pkg::CA_MRW : mra_pkg::CA_MRR;
	wire [7:0] cmd_data = is_wr ? i_req_data : 8'h00;
	wire [15:0] hold_cycles = ~is_wr ? 16'(mra_pkg::MRR_TURN_CYCLES) :
		(req_reset ? 16'(INIT_CYCLES) : 16'(WRITE_CYCLES));
	wire poll_tick = poll_cnt_reg == 32'(POLL_CYCLES - 1);

	assign o_req_ready = idle & ~poll_pend_reg & req_ok;

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			state_reg <= CS_IDLE;
			wait_reg <= 16'h0000;
			cs_n_reg <= 1'b1;
			cke_reg <= 1'b1;
			ca_rise_reg <= 10'h000;
			ca_fall_reg <= 10'h000;
		end else begin
			cs_n_reg <= 1'b1;
			if (state_reg == CS_IDLE) begin
				cke_reg <= ~i_power_down;
			end
			if (issue_poll | issue_req) begin
				state_reg <= CS_WAIT;
				wait_reg <= hold_cycles;
				cs_n_reg <= 1'b0;
				ca_rise_reg <= {cmd_addr[5:0], cmd_op};
				ca_fall_reg <= {cmd_data, cmd_addr[7:6]};
			end else if (state_reg == CS_WAIT) begin
				if (wait_reg == 16'h0001) begin
					state_reg <= CS_IDLE;
				end
				wait_reg <= wait_reg - 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// spacing after array bursts and poll timer
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			gap_reg <= 8'h00;
			poll_cnt_reg <= 32'h0000_0000;
			poll_pend_reg <= 1'b0;
		end else begin
			if (i_array_write) begin
				gap_reg <= 8'(mra_pkg::WR_TO_MRR_CYCLES);
			end else if (i_array_read & (gap_reg < 8'(2))) begin
				gap_reg <= 8'(mra_pkg::RD_TO_MRR_CYCLES);
			end else if (!gap_ok) begin
				gap_reg <= gap_reg - 8'h01;
			end
			poll_cnt_reg <= poll_tick ? 32'h0000_0000 :
				poll_cnt_reg + 32'h0000_0001;
			if (poll_tick) begin
				poll_pend_reg <= 1'b1;
			end else if (issue_poll) begin
				poll_pend_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// read data capture
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			poll_rd_reg <= 1'b0;
			beat_reg <= 3'h0;
			rd_data_reg <= 8'h00;
			rd_cal_reg <= 4'h0;
			rd_valid_reg <= 1'b0;
			temp_reg <= mra_pkg::TEMP_STATUS_RESET;
		end else begin
			rd_valid_reg <= 1'b0;
			if (issue_poll | issue_req) begin
				poll_rd_reg <= issue_poll;
				beat_reg <= 3'h0;
			end else if (link.dq_oe) begin
				beat_reg <= beat_reg + 3'h1;
				rd_cal_reg[beat_reg[1:0]] <= link.dq[0];
				if (beat_reg == 3'h0) begin
					rd_data_reg <= link.dq[7:0];
					if (poll_rd_reg) begin
						temp_reg <= link.dq[2:0];
					end
				end
				if (beat_reg == 3'(mra_pkg::MRR_BEATS - 1)) begin
					rd_valid_reg <= ~poll_rd_reg;
				end
			end
		end
	end

	assign link.cs_n = cs_n_reg;
	assign link.cke = cke_reg;
	assign link.ca_rise = ca_rise_reg;
	assign link.ca_fall = ca_fall_reg;
	assign o_rd_valid = rd_valid_reg;
	assign o_rd_data = rd_data_reg;
	assign o_rd_cal = rd_cal_reg;
	assign o_temp_status = temp_reg;
endmodule

// [mra_link_asserts.sv]
// link protocol assertions for the mode register access unit
`timescale 1ns/10ps
module mra_link_asserts (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// link
	input wire logic cs_n,
	input wire logic cke,
	input wire logic [9:0] ca_rise,
	input wire logic [9:0] ca_fall,
	input wire logic [15:0] dq,
	input wire logic dq_oe,
	input wire logic dqs
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	wire logic cmd = !cs_n && cke;
	wire logic [7:0] addr = {ca_fall[1:0], ca_rise[9:4]};
	wire logic mrr = cmd && ca_rise[3:0] == 4'h8;
	wire logic mrw = cmd && ca_rise[3:0] == 4'h0;
	wire logic plain = addr != 8'h20 && addr != 8'h28;
	sequence s_burst;
		dq_oe [*4] ##1 !dq_oe;
	endsequence
	sequence s_toggle;
		dqs ##1 !dqs ##1 dqs ##1 !dqs;
	endsequence
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_mrr_burst;
		mrr |-> ##4 s_burst;
	endproperty
	property p_mrr_nop;
		mrr |=> cs_n [*8];
	endproperty
	property p_mrw_nop;
		mrw |=> cs_n [*4];
	endproperty
	property p_strobe;
		$rose(dq_oe) |-> s_toggle;
	endproperty
	property p_quiet;
		!dq_oe |-> dq == 16'h0 && !dqs;
	endproperty
	property p_cal_a;
		mrr && addr == 8'h20 |-> ##4 dq == 16'hffff ##1 dq == 16'h0
			##1 dq == 16'hffff ##1 dq == 16'h0;
	endproperty
	property p_cal_b;
		mrr && addr == 8'h28 |-> ##4 dq == 16'h0 ##1 dq == 16'h0
			##1 dq == 16'hffff ##1 dq == 16'hffff;
	endproperty
	property p_plain;
		mrr && plain |-> ##4 dq[15:8] == 8'h00 ##1 dq == 16'h0 [*3];
	endproperty
	a_mrr_burst: assert property (p_mrr_burst)
		else $error("read burst is not four beats");
	a_mrr_nop: assert property (p_mrr_nop)
		else $error("command inside read period");
	a_mrw_nop: assert property (p_mrw_nop)
		else $error("command inside write period");
	a_strobe: assert property (p_strobe)
		else $error("strobe does not toggle per beat");
	a_quiet: assert property (p_quiet)
		else $error("data lines busy outside burst");
	a_cal_a: assert property (p_cal_a)
		else $error("pattern a wrong");
	a_cal_b: assert property (p_cal_b)
		else $error("pattern b wrong");
	a_plain: assert property (p_plain)
		else $error("plain read carries data outside low byte");
endmodule

// [test_mode_register_access_unit.sv]
// self-checking bench for the mode register access unit
`timescale 1ns/10ps
module test_mode_register_access_unit;
	logic clk = 0;
	logic rst = 1;
	logic rq_v = 0, rq_w = 0, a_wr = 0, a_rd = 0, pd = 0, bk_act = 0;
	logic bk_idle = 1;
	logic [7:0] rq_a = 8'h00, rq_d = 8'h00;
	logic [2:0] temp = 3'h3;
	wire logic rdy, rd_v, idle, init, wr_v;
	wire logic [7:0] rd_d, wr_a, wr_d;
	wire logic [3:0] rd_cal;
	wire logic [2:0] t_st;
	int n_fail = 0, num_checks = 0, cyc = 0, last_cmd = 0, n_wr = 0;
	// ------------------------------------------------------------
	// both ends and checker
	// ------------------------------------------------------------
	mra_link_if u_mra_link_if ();
	mra_mem_device #(.SENSOR_CYCLES(50)) u_mra_mem_device (
		.i_core_clk(clk), .i_reset(rst), .link(u_mra_link_if.dev),
		.i_banks_active(bk_act), .i_temp_sensor(temp), .o_idle(idle),
		.o_initializing(init), .o_mr_wr_valid(wr_v),
		.o_mr_wr_addr(wr_a), .o_mr_wr_data(wr_d));
	mra_mem_ctrl #(.POLL_CYCLES(200)) u_mra_mem_ctrl (
		.i_core_clk(clk), .i_reset(rst), .link(u_mra_link_if.ctrl),
		.i_req_valid(rq_v), .i_req_write(rq_w), .i_req_addr(rq_a),
		.i_req_data(rq_d), .o_req_ready(rdy), .i_banks_idle(bk_idle),
		.i_array_write(a_wr), .i_array_read(a_rd), .i_power_down(pd),
		.o_rd_valid(rd_v), .o_rd_data(rd_d), .o_rd_cal(rd_cal),
		.o_temp_status(t_st));
	mra_link_asserts u_mra_link_asserts (
		.i_core_clk(clk), .i_reset(rst), .cs_n(u_mra_link_if.cs_n),
		.cke(u_mra_link_if.cke), .ca_rise(u_mra_link_if.ca_rise),
		.ca_fall(u_mra_link_if.ca_fall), .dq(u_mra_link_if.dq),
		.dq_oe(u_mra_link_if.dq_oe), .dqs(u_mra_link_if.dqs));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (u_mra_link_if.cs_n === 1'b0) last_cmd = cyc;
		if (wr_v === 1'b1) n_wr++;
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task automatic req(input logic w, input logic [7:0] a, d);
		int n;
		n = 0;
		@(negedge clk);
		rq_v = 1;
		rq_w = w;
		rq_a = a;
		rq_d = d;
		#1;
		while (rdy !== 1'b1 && n < 300) begin
			@(negedge clk);
			#1;
			n++;
		end
		chk("req_ready", 16'(n < 300), 16'h1);
		@(negedge clk);
		rq_v = 0;
		n = 0;
		while (!w && rd_v !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		if (!w) chk("rd_valid", 16'(rd_v), 16'h1);
		if (w) repeat (4) @(negedge clk);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		chk("temp_status", 16'(t_st), 16'h3);
		chk("idle", 16'(idle), 16'h1);
		chk("cs_n", 16'(u_mra_link_if.cs_n), 16'h1);
		$display("test reset done");
	endtask
	task automatic t_write;
		int w0;
		w0 = n_wr;
		req(1, 8'hd1, 8'h96);
		chk("wr_pulses", 16'(n_wr - w0), 16'h1);
		chk("wr_addr", 16'(wr_a), 16'hd1);
		chk("wr_data", 16'(wr_d), 16'h96);
		req(0, 8'hd1, 8'h00);
		chk("rd_data", 16'(rd_d), 16'h96);
		$display("test write done");
	endtask
	task automatic t_status;
		int w0;
		temp = 3'h5;
		w0 = n_wr;
		req(1, 8'h04, 8'hff);
		chk("ro_pulses", 16'(n_wr - w0), 16'h0);
		repeat (60) @(negedge clk);
		req(0, 8'h04, 8'h00);
		chk("status", 16'(rd_d), 16'h5);
		repeat (220) @(negedge clk);
		chk("polled", 16'(t_st), 16'h5);
		$display("test status done");
	endtask
	task automatic t_calib;
		logic [7:0] ad[2] = '{8'h20, 8'h28};
		for (int i = 0; i < 2; i++) begin
			req(0, ad[i], 8'h00);
			chk("cal_bits", 16'(rd_cal), i ? 16'hc : 16'h5);
			chk("cal_byte", 16'(rd_d), i ? 16'h00 : 16'hff);
		end
		$display("test calib done");
	endtask
	task automatic t_active;
		int w0;
		bk_idle = 0;
		repeat (4) @(negedge clk);
		rq_w = 1;
		rq_a = 8'h33;
		#1;
		chk("wr_ready", 16'(rdy), 16'h0);
		rq_w = 0;
		rq_a = 8'h20;
		#1;
		chk("cal_ready", 16'(rdy), 16'h0);
		bk_idle = 1;
		bk_act = 1;
		w0 = n_wr;
		req(1, 8'h33, 8'h5a);
		chk("act_pulses", 16'(n_wr - w0), 16'h0);
		req(0, 8'hd1, 8'h00);
		chk("act_read", 16'(rd_d), 16'h96);
		bk_act = 0;
		$display("test active done");
	endtask
	task automatic t_gap;
		int t0;
		for (int i = 0; i < 2; i++) begin
			repeat (4) @(negedge clk);
			a_wr = (i == 0);
			a_rd = (i == 1);
			t0 = cyc + 1;
			@(negedge clk);
			a_wr = 0;
			a_rd = 0;
			rq_w = 0;
			rq_a = 8'hd1;
			#1;
			chk("gap_ready", 16'(rdy), 16'h0);
			req(0, 8'hd1, 8'h00);
			chk("gap", 16'(last_cmd - t0 >= (i ? 2 : 6)), 16'h1);
		end
		$display("test gap done");
	endtask
	task automatic t_power;
		pd = 1;
		repeat (20) @(negedge clk);
		chk("cke", 16'(u_mra_link_if.cke), 16'h0);
		temp = 3'h6;
		repeat (4) @(negedge clk);
		pd = 0;
		req(0, 8'h04, 8'h00);
		chk("fresh", 16'(rd_d), 16'h6);
		$display("test power done");
	endtask
	task automatic t_reset_form;
		req(1, 8'h3f, 8'h00);
		chk("init", 16'(init), 16'h1);
		req(0, 8'hd1, 8'h00);
		chk("cleared", 16'(rd_d), 16'h0);
		chk("idle", 16'(idle), 16'h1);
		$display("test reset form done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		t_reset;
		t_write;
		t_status;
		t_calib;
		t_active;
		t_gap;
		t_power;
		t_reset_form;
		report_and_stop;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		report_and_stop;
	end
endmodule
